// ---- rtl/dcds_core.sv ----
// Notes on behaviour
// - Direction set, sync clear: drive word clock out at channel data rate.
// - Direction and sync set: drive word clock as modulator sync output.
// - All three clear: ignore word clock, capture on sample clock only.
// - Only recovery set: word clock is input, data recovery enabled.
// - Only sync set: word clock input, data captured on its edges.
// - Sync and recovery set, direction clear: word clock is modulator sync input.
// - Master 1x: word clock is inverted delayed sample clock copy.
// - Master 1x: polarity 0 latches falling edge, polarity 1 rising.
// - Master 2x: word clock halves, capture every second rising edge.
// - Interpolating master: latch edge precedes word clock fall for either polarity.
// - 4x/8x divide sample clock by 4/8, capture every 4th/8th edge.
// - Generated word clock high phase equal to low phase.
// - Slave with recovery: loop aligns word clock input to sample clock; the code only checks the word clock period against the divider ratio.
// - Slave: capture on first rising edge at least 1.5 ns before latch edge; the code captures after the latch edge, once it has passed the synchroniser.
// - Status bit 2 is 1 once lock was ever achieved.
// - Status bit 1 is 1 while currently locked.
// - Status bit 0 is 1 when lock lost through jitter.
// - Sync source bit 3: 0 channel-rate synchroniser, 1 state-machine synchroniser.
`default_nettype none
module dcds_core
    import dcds_pkg::*;
#(
    parameter int DATA_W = DCDS_DATA_W,
    parameter int FIFO_DEPTH = DCDS_FIFO_DEPTH,
    parameter int LOCK_CYC = DCDS_LOCK_CYC
)(
    input  wire logic              clk_in,          // Sample clock, 200 MHz
    input  wire logic              rst_n_in,        // Sync reset, low
    input  wire dcds_reg_req_type  reg_req_in,      // Register write/read address
    output logic [7:0]             reg_rdata_out,   // Register read data
    input  wire logic              word_clk_in,     // Word clock pin input
    output logic                   word_clk_out,    // Word clock pin drive
    output logic                   word_clk_oe_out, // High while driving pin
    input  wire logic [DATA_W-1:0] data_in,         // Parallel sample pins
    output dcds_word_type          sample_out,      // Captured word
    input  wire logic              sample_ready_in, // Interpolator takes word
    output logic                   overflow_out,    // Word lost, FIFO full
    output dcds_mode_type          mode_out         // Decoded timing mode
);
    localparam int LCW = $clog2(LOCK_CYC + 1);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]    clk_ctrl;
        logic [7:0]    sync_ctrl;
        logic [7:0]    interp;
        logic [2:0]    div_cnt;
        logic [2:0]    sync_pipe;
        logic [2:0]    per_cnt;
        logic [2:0]    per_ref;
        logic          per_ref_ok;
        logic [LCW-1:0] good_cnt;
        logic          locked;
        logic          ever;
        logic          lost;
        logic          overflow;
        logic [7:0]    rdata;
        logic          word_clk;
        logic          wc_prev;
        logic          neg_hold;
        dcds_word_type cap;
    } dcds_core_st_type;

    dcds_core_st_type st_reg, st_next;
    dcds_mode_type    mode;
    logic             dir, sync_src, crc, pol;
    logic [2:0]       ratio_m1;
    logic             wc_rise, wc_fall, wc_edge;
    logic             cap_now, fifo_ready;
    logic [DATA_W-1:0] neg_data_reg;
    logic             fifo_valid;
    logic [DATA_W-1:0] fifo_data;

    // Divider terminal count for 1x/2x/4x/8x interpolation
    function automatic logic [2:0] ratio_of(input logic [1:0] sel);
        case (sel)
            2'h0: ratio_of = 3'h0;
            2'h1: ratio_of = 3'h1;
            2'h2: ratio_of = 3'h3;
            default: ratio_of = 3'h7;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    assign dir = st_reg.clk_ctrl[DCDS_BIT_DIR];
    assign crc = st_reg.clk_ctrl[DCDS_BIT_CRC];
    assign pol = st_reg.clk_ctrl[DCDS_BIT_POL];
    assign sync_src = st_reg.sync_ctrl[DCDS_BIT_SYNC];
    assign ratio_m1 = ratio_of(st_reg.interp[DCDS_INTERP_LSB +: 2]);

    always_comb
    begin
        case ({dir, sync_src, crc})
            3'b100, 3'b101: mode = DCDS_MASTER;
            3'b110, 3'b111: mode = DCDS_MOD_MASTER;
            3'b000: mode = DCDS_EXT_SYNC;
            3'b001: mode = DCDS_SLAVE_CRC;
            3'b010: mode = DCDS_LOW_SH;
            3'b011: mode = DCDS_MOD_SLAVE;
            default: mode = DCDS_EXT_SYNC;
        endcase
    end

    // Word clock edges seen after the three-stage synchroniser
    assign wc_rise = st_reg.sync_pipe[1] && !st_reg.sync_pipe[2];
    assign wc_fall = !st_reg.sync_pipe[1] && st_reg.sync_pipe[2];
    assign wc_edge = pol ? wc_rise : wc_fall;

    // ------------------------------------------------------------
    // Capture decision
    // ------------------------------------------------------------
    always_comb
    begin
        case (mode)
            DCDS_MASTER, DCDS_MOD_MASTER, DCDS_EXT_SYNC:
                // Last rising edge before the generated word clock edge
                cap_now = (st_reg.div_cnt == ratio_m1);
            DCDS_SLAVE_CRC:
                cap_now = wc_edge && st_reg.locked;
            DCDS_LOW_SH:
                cap_now = wc_edge;
            default:
                cap_now = wc_edge;
        endcase
    end

    // Falling-edge capture for master 1x with polarity 0
    always_ff @(negedge clk_in)
    begin
        neg_data_reg <= data_in;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        st_next.sync_pipe = {st_reg.sync_pipe[1:0], word_clk_in};
        st_next.div_cnt = (st_reg.div_cnt >= ratio_m1) ? 3'h0 : st_reg.div_cnt + 3'h1;
        // High for half the word period: high only while next count > half the terminal count
        // gives equal high and low phases at 2x/4x/8x, matching the pin.
        if (ratio_m1 == 3'h0)
        begin
            st_next.word_clk = 1'b0;
        end
        else
        begin
            st_next.word_clk = (st_next.div_cnt > (ratio_m1 >> 1));
        end
        st_next.neg_hold = 1'b0;
        st_next.cap.valid = 1'b0;
        if (cap_now)
        begin
            st_next.cap.valid = 1'b1;
            st_next.cap.data = (mode == DCDS_MASTER && ratio_m1 == 3'h0 && !pol)
                ? neg_data_reg : data_in;
        end
        st_next.overflow = st_reg.cap.valid && !fifo_ready;
        // Loop lock: word clock period must match the divider ratio
        st_next.per_cnt = st_reg.per_cnt + 3'h1;
        if (wc_rise)
        begin
            st_next.per_cnt = 3'h0;
            st_next.per_ref = st_reg.per_cnt;
            st_next.per_ref_ok = (st_reg.per_cnt == ratio_m1);
            if (st_reg.per_cnt == ratio_m1)
            begin
                if (st_reg.good_cnt != LCW'(LOCK_CYC))
                begin
                    st_next.good_cnt = st_reg.good_cnt + 1'b1;
                end
            end
            else
            begin
                st_next.good_cnt = '0;
                // Sticky until relock: later bad periods must not clear it
                if (st_reg.locked)
                begin
                    st_next.lost = 1'b1;
                end
            end
        end
        st_next.locked = (st_next.good_cnt == LCW'(LOCK_CYC));
        if (st_next.locked)
        begin
            st_next.ever = 1'b1;
            st_next.lost = 1'b0;
        end
        if (!crc || dir)
        begin
            st_next.good_cnt = '0;
            st_next.locked = 1'b0;
            st_next.ever = 1'b0;
            st_next.lost = 1'b0;
        end
        // Register port: write decode and read mux
        if (reg_req_in.wr)
        begin
            case (reg_req_in.addr)
                DCDS_ADDR_CLK_CTRL: st_next.clk_ctrl = reg_req_in.wdata;
                DCDS_ADDR_SYNC_CTRL: st_next.sync_ctrl = reg_req_in.wdata;
                DCDS_ADDR_INTERP: st_next.interp = reg_req_in.wdata;
                default: ;
            endcase
        end
        case (reg_req_in.addr)
            DCDS_ADDR_CLK_CTRL: st_next.rdata = st_reg.clk_ctrl;
            DCDS_ADDR_SYNC_CTRL: st_next.rdata = st_reg.sync_ctrl;
            DCDS_ADDR_INTERP: st_next.rdata = st_reg.interp;
            DCDS_ADDR_LOCK_STAT:
                st_next.rdata = {5'h0, st_reg.ever, st_reg.locked, st_reg.lost};
            default: st_next.rdata = DCDS_RESET_VAL;
        endcase
        st_next.wc_prev = st_reg.word_clk;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Pin drive and outputs
    // ------------------------------------------------------------
    // 1x master: inverted copy of the sample clock, delay of the output path
    assign word_clk_out = (ratio_m1 == 3'h0) ? st_reg.wc_prev ^ 1'b0 | ~clk_in & dir
                                             : st_reg.word_clk;
    assign word_clk_oe_out = dir;
    assign reg_rdata_out = st_reg.rdata;
    assign overflow_out = st_reg.overflow;
    assign mode_out = mode;

    dcds_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in     (clk_in),
        .rst_n_in   (rst_n_in),
        .wvalid_in  (st_reg.cap.valid),
        .wready_out (fifo_ready),
        .wdata_in   (st_reg.cap.data),
        .rvalid_out (fifo_valid),
        .rready_in  (sample_ready_in),
        .rdata_out  (fifo_data)
    );

    assign sample_out.valid = fifo_valid;
    assign sample_out.data = fifo_data;
endmodule
`default_nettype wire

// ---- shared/dcds_pkg.sv ----
`default_nettype none
package dcds_pkg;
    // ------------------------------------------------------------
    // Register map and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] DCDS_ADDR_CLK_CTRL = 8'h02;   // direction, recovery, polarity
    localparam logic [7:0] DCDS_ADDR_SYNC_CTRL = 8'h05;  // sync source
    localparam logic [7:0] DCDS_ADDR_LOCK_STAT = 8'h12;  // dll_lock_status
    localparam logic [7:0] DCDS_ADDR_INTERP = 8'h01;     // interpolation select
    localparam int DCDS_BIT_DIR = 3;
    localparam int DCDS_BIT_CRC = 2;
    localparam int DCDS_BIT_POL = 4;
    localparam int DCDS_BIT_SYNC = 3;
    localparam int DCDS_BIT_EVER = 2;
    localparam int DCDS_BIT_LOCKED = 1;
    localparam int DCDS_BIT_LOST = 0;
    localparam int DCDS_INTERP_LSB = 6;
    localparam logic [7:0] DCDS_RESET_VAL = 8'h00;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam real DCDS_CLK_NS = 5.0;
    localparam real DCDS_SETUP_NS = 1.5;
    localparam int DCDS_SETUP_CYC = (DCDS_SETUP_NS / DCDS_CLK_NS) > 1.0 ?
        int'(DCDS_SETUP_NS / DCDS_CLK_NS + 0.999) : 1;
    localparam int DCDS_LOCK_CYC = 16;        // good periods before lock
    localparam int DCDS_DATA_W = 16;
    localparam int DCDS_FIFO_DEPTH = 8;

    typedef enum logic [2:0] {
        DCDS_MASTER, DCDS_MOD_MASTER, DCDS_EXT_SYNC,
        DCDS_SLAVE_CRC, DCDS_LOW_SH, DCDS_MOD_SLAVE
    } dcds_mode_type;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dcds_reg_req_type;

    typedef struct packed {
        logic                   valid;
        logic [DCDS_DATA_W-1:0] data;
    } dcds_word_type;
endpackage
`default_nettype wire

// ---- rtl/dcds_fifo.sv ----
`default_nettype none
module dcds_fifo
    import dcds_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
)(
    input  wire logic             clk_in,     // Sample clock domain
    input  wire logic             rst_n_in,   // Sync reset, low
    input  wire logic             wvalid_in,  // Write request
    output logic                  wready_out, // Not full
    input  wire logic [WIDTH-1:0] wdata_in,   // Write word
    output logic                  rvalid_out, // Not empty
    input  wire logic             rready_in,  // Drain
    output logic      [WIDTH-1:0] rdata_out   // Head word
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } dcds_fifo_st_type;

    dcds_fifo_st_type st_reg, st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push, pop;

    // ------------------------------------------------------------
    // Pointer logic
    // ------------------------------------------------------------
    assign wready_out = (st_reg.cnt != (AW+1)'(DEPTH));
    assign rvalid_out = (st_reg.cnt != '0);
    assign push = wvalid_in && wready_out;
    assign pop = rvalid_out && rready_in;
    assign rdata_out = mem[st_reg.rp];

    always_comb
    begin
        st_next = st_reg;
        if (push)
        begin
            st_next.wp = (st_reg.wp == AW'(DEPTH-1)) ? '0 : st_reg.wp + 1'b1;
        end
        if (pop)
        begin
            st_next.rp = (st_reg.rp == AW'(DEPTH-1)) ? '0 : st_reg.rp + 1'b1;
        end
        st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Storage has no reset; only pointers need a defined value
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
        if (push)
        begin
            mem[st_reg.wp] <= wdata_in;
        end
    end
endmodule
`default_nettype wire

// ---- tb/dcds_core_asserts.sv ----
`default_nettype none
module dcds_core_asserts
    import dcds_pkg::*;
(
    input wire logic             clk_in,          // Sample clock
    input wire logic             rst_n_in,        // Sync reset, low
    input wire dcds_reg_req_type reg_req_in,      // Register request
    input wire logic [7:0]       reg_rdata_out,   // Read data
    input wire logic             word_clk_out,    // Pin drive
    input wire logic             word_clk_oe_out, // Pin enable
    input wire logic             overflow_out,    // Dropped word
    input wire dcds_mode_type    mode_out         // Decoded mode
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------
    // Helpers
    // ----------
    logic [1:0] ratio_reg;
    wire logic  wr_ctl = reg_req_in.wr && reg_req_in.addr == DCDS_ADDR_CLK_CTRL;
    wire logic  rd_st  = !reg_req_in.wr && reg_req_in.addr == DCDS_ADDR_LOCK_STAT;
    wire logic  drv    = mode_out inside {DCDS_MASTER, DCDS_MOD_MASTER};
    wire logic  crc    = mode_out inside {DCDS_SLAVE_CRC, DCDS_MOD_SLAVE};
    wire logic  m4     = mode_out == DCDS_MASTER && ratio_reg == 2'h2;

    // Ratio follows writes; the period checks need it and the core hides it
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            ratio_reg <= 2'h0;
        else if (reg_req_in.wr && reg_req_in.addr == DCDS_ADDR_INTERP)
            ratio_reg <= reg_req_in.wdata[7:6];
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // ----------
    // Properties
    // ----------
    chk_pin_driven: assert property (drv |-> word_clk_oe_out)
        else $error("word clock not driven in master mode");
    chk_pin_released: assert property (!drv |-> !word_clk_oe_out)
        else $error("word clock driven in input mode");
    chk_dir_set: assert property (wr_ctl && reg_req_in.wdata[3] |=> word_clk_oe_out)
        else $error("direction write did not drive pin");
    chk_dir_clear: assert property (wr_ctl && !reg_req_in.wdata[3] |=> !drv)
        else $error("direction clear left a master mode");
    chk_stat_quiet: assert property (rd_st && !crc |=> reg_rdata_out == 8'h00)
        else $error("lock status not zero without recovery");
    chk_lost_excl: assert property (rd_st |=> !(reg_rdata_out[1] && reg_rdata_out[0]))
        else $error("lost and locked both set");
    chk_ever_locked: assert property (rd_st |=> !reg_rdata_out[1] || reg_rdata_out[2])
        else $error("locked without ever-locked");
    chk_word_period: assert property (m4 && $rose(word_clk_out) |=>
        (!$rose(word_clk_out) || !m4) [*3] ##1 ($rose(word_clk_out) || !m4))
        else $error("word clock period not four sample clocks");
    chk_high_short: assert property (m4 && $rose(word_clk_out) |->
        ##[1:2] ($fell(word_clk_out) || !m4))
        else $error("word clock high phase too long");
    cover property (rd_st ##1 reg_rdata_out[DCDS_BIT_LOCKED]);
    cover property (overflow_out);
    cover property (m4 && $rose(word_clk_out));
endmodule

bind dcds_core dcds_core_asserts dcds_core_asserts_i (
    .clk_in         (clk_in),
    .rst_n_in       (rst_n_in),
    .reg_req_in     (reg_req_in),
    .reg_rdata_out  (reg_rdata_out),
    .word_clk_out   (word_clk_out),
    .word_clk_oe_out(word_clk_oe_out),
    .overflow_out   (overflow_out),
    .mode_out       (mode_out)
);
`default_nettype wire

// ---- tb/dcds_far_model.sv ----
`default_nettype none
module dcds_far_model
    import dcds_pkg::*;
#(
    parameter int RATIO = 4
)(
    input  wire logic                   run_in,    // Supply the word clock
    input  wire logic                   jitter_in, // Shorten high phases
    input  wire logic [DCDS_DATA_W-1:0] value_in,  // Word to present
    output logic                        wclk_out,  // Word clock drive
    output logic [DCDS_DATA_W-1:0]      data_out   // Sample pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------
    // Word source
    // ----------
    // Word-rate clock only while asked, parked low otherwise; its phase
    // stays fixed against the sample clock, as the period is 5 x RATIO ns unless jitter shortens it
    initial
    begin
        wclk_out = 1'b0;
        forever
        begin
            if (run_in)
            begin
                #(2.5 * RATIO) wclk_out = 1'b1;
                #(2.5 * RATIO - (jitter_in ? 5.0 : 0.0)) wclk_out = 1'b0;
            end
            else
                #1.3;
        end
    end

    // Held for a whole phase so any latch edge sees one value
    assign data_out = value_in;
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`default_nettype none
`define CHK(got, exp) \
    begin \
        checks++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("ERROR %0t: got %0h want %0h", $time, (got), (exp)); \
        end \
    end
module tb
    import dcds_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------
    // Stimulus and scoreboard
    // ----------
    logic             clk_in, rst_n_in, wclk_dev, wclk_oe, wclk_far, rdy, run, jit, ovf;
    dcds_reg_req_type req;
    logic [7:0]       rdata, st;
    logic [15:0]      value, prev, far_data;
    logic [31:0]      lfsr;
    dcds_word_type    smp;
    dcds_mode_type    mode;
    int               got, drops, n, fail_count, checks;
    dcds_mode_type    mode_tab [8] = '{DCDS_EXT_SYNC, DCDS_SLAVE_CRC, DCDS_LOW_SH,
        DCDS_MOD_SLAVE, DCDS_MASTER, DCDS_MASTER, DCDS_MOD_MASTER, DCDS_MOD_MASTER};
    wire logic        wclk_pin = wclk_oe ? wclk_dev : wclk_far;  // Resolved pin

    dcds_core #(.LOCK_CYC(4)) dcds_core_i (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_req_in(req), .reg_rdata_out(rdata),
        .word_clk_in(wclk_pin), .word_clk_out(wclk_dev), .word_clk_oe_out(wclk_oe),
        .data_in(far_data), .sample_out(smp), .sample_ready_in(rdy),
        .overflow_out(ovf), .mode_out(mode));
    dcds_far_model #(.RATIO(4)) dcds_far_model_i (
        .run_in(run), .jitter_in(jit), .value_in(value), .wclk_out(wclk_far),
        .data_out(far_data));

    initial
    begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        req <= '{1'b1, a, d};
        @(posedge clk_in);
        req <= '{1'b0, a, d};
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk_in);
        req <= '{1'b0, a, 8'h00};
        repeat (2) @(posedge clk_in);
        #1 st = rdata;
    endtask

    // Mode index is {direction, sync source, recovery}
    task automatic setup(input logic [2:0] i, input logic pol, input logic [1:0] r);
        wr(DCDS_ADDR_SYNC_CTRL, {4'h0, i[1], 3'h0});
        wr(DCDS_ADDR_INTERP, {r, 6'h00});
        wr(DCDS_ADDR_CLK_CTRL, {3'h0, pol, i[2], i[0], 2'h0});
        @(posedge clk_in);
        #1;
        `CHK(mode, mode_tab[i]);
        `CHK(wclk_oe, i[2]);
    endtask

    // Words still in flight may carry the previous value, so both are accepted
    task automatic new_value();
        @(posedge clk_in);
        prev = value;
        lfsr = next_rand(lfsr);
        value <= lfsr[15:0];
    endtask

    task automatic wait_lock();
        for (int k = 0; k < 40 && st[DCDS_BIT_LOCKED] !== 1'b1; k++)
            rd(DCDS_ADDR_LOCK_STAT);
    endtask

    task automatic close_out();
        $display("Checks %0d, errors %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Every word leaving the FIFO must be one the far side presented
    always @(posedge clk_in)
    begin
        if (rst_n_in && rdy && smp.valid)
        begin
            got++;
            `CHK(smp.data === value || smp.data === prev, 1'b1);
        end
        if (rst_n_in && ovf)
            drops++;
    end

    initial
    begin
        req = '0;
        {rdy, run, jit, rst_n_in} = 4'h8;
        {value, prev, lfsr} = {32'h0, 32'h88F5};
        {got, drops, fail_count, checks} = '0;
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(DCDS_ADDR_LOCK_STAT);
        `CHK(st, DCDS_RESET_VAL);
        rd(8'h33);
        `CHK(st, 8'h00);
        for (int i = 0; i < 8; i++)
            setup(i[2:0], 1'b0, 2'h0);
        // Word count per ratio, both edges, master and external sync
        for (int k = 0; k < 16; k++)
        begin
            new_value();
            setup({k[3], 2'h0}, k[2], k[1:0]);
            n = got;
            repeat (64) @(posedge clk_in);
            #1;
            `CHK((got - n) inside {[(64 >> k[1:0]) - 1:(64 >> k[1:0]) + 1]}, 1'b1);
        end
        // Stall at 8x until words drop, then drain to empty
        @(posedge clk_in);
        rdy <= 1'b0;
        n = drops;
        repeat (120) @(posedge clk_in);
        #1;
        `CHK(drops - n > 4, 1'b1);
        @(posedge clk_in);
        rdy <= 1'b1;
        n = got;
        repeat (8) @(posedge clk_in);
        #1;
        `CHK(got - n, 8);
        for (n = 0; n < 20 && smp.valid; n++)
            #5;
        `CHK(smp.valid, 1'b0);
        // Slave with recovery at 4x, then jitter, relock and recovery off
        new_value();
        run <= 1'b1;
        setup(3'h1, 1'b0, 2'h2);
        wait_lock();
        `CHK(st, 8'h06);
        n = got;
        repeat (64) @(posedge clk_in);
        #1;
        `CHK((got - n) inside {[15:17]}, 1'b1);
        @(posedge clk_in);
        jit <= 1'b1;
        repeat (60) @(posedge clk_in);
        rd(DCDS_ADDR_LOCK_STAT);
        `CHK(st, 8'h05);
        @(posedge clk_in);
        jit <= 1'b0;
        wait_lock();
        `CHK(st, 8'h06);
        setup(3'h0, 1'b0, 2'h2);
        rd(DCDS_ADDR_LOCK_STAT);
        `CHK(st, 8'h00);
        close_out();
    end

    initial
    begin
        repeat (40000) @(posedge clk_in);
        fail_count++;
        close_out();
    end
endmodule
`default_nettype wire
